// file: hw/cirv_top.sv
// interrupt gathering, vectoring and reset entry logic of the core
// assumes core ticks once per instruction cycle and reports sleep and pc
`timescale 1ns/100ps
module cirv_top (
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  input  wire logic                      ext_pin,
  input  wire logic                      pin_edge_select,
  input  wire logic [7:0]                timer_zero,
  input  wire logic                      port_change,
  input  wire logic [cirv_pkg::NUM_PER-1:0] per_event,
  input  wire logic                      instr_tick,
  input  wire logic                      sleep_mode,
  input  wire logic                      return_from_interrupt_instr,
  input  wire logic [cirv_pkg::PC_W-1:0] core_pc,
  input  wire cirv_pkg::cirv_rst_s       rst_cause,
  output cirv_pkg::cirv_cmd_s            core_cmd,
  output logic                           irq_req,
  output logic                           wake
);
  import cirv_pkg::*;

  logic [7:0]     core_ic_reg, core_ic_next;
  logic [7:0]     per_flag_reg, per_flag_next;
  logic [7:0]     per_en_reg, per_en_next;
  logic [2:0]     pwr_reg, pwr_next;
  logic           to_reg, to_next, pd_reg, pd_next;
  logic [7:0]     rdata_reg, rdata_next;
  cirv_cmd_s      cmd_reg, cmd_next;
  logic           irq_reg, irq_next, wake_reg, wake_next;
  cirv_svc_e      svc_reg, svc_next;
  logic           pin_s1_reg, pin_s2_reg, pin_s3_reg;
  logic [7:0]     tmr_prev_reg;
  logic           any_rst, pin_edge, tmr_roll, masked_any, take;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // pin comes from outside; second stage feeds the third and, with it, the edge detect
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_s1_reg   <= 1'b0;
      pin_s2_reg   <= 1'b0;
      pin_s3_reg   <= 1'b0;
      tmr_prev_reg <= 8'h00;
    end else begin
      pin_s1_reg   <= ext_pin;
      pin_s2_reg   <= pin_s1_reg;
      pin_s3_reg   <= pin_s2_reg;
      tmr_prev_reg <= timer_zero;
    end
  end

  assign pin_edge = pin_edge_select ? (pin_s2_reg & ~pin_s3_reg)
                                    : (~pin_s2_reg & pin_s3_reg);
  assign tmr_roll = (tmr_prev_reg == TIMER_ZERO_TOP) && (timer_zero == TIMER_ZERO_ZERO);
  assign any_rst  = rst_cause.por | rst_cause.ext_rst | rst_cause.wdt_rst | rst_cause.bor;
  // group gating without the global enable is also what wakes from sleep
  assign masked_any = |(core_ic_reg[2:0] & {core_ic_reg[IC_T0IE], core_ic_reg[IC_INTE], core_ic_reg[IC_RAIE]})
                    | (core_ic_reg[IC_PERIPHERAL_GROUP_ENABLE] & |(per_flag_reg & per_en_reg));
  assign take = masked_any & core_ic_reg[IC_GIE];

  always_comb begin
    core_ic_next  = core_ic_reg;
    per_flag_next = per_flag_reg;
    per_en_next   = per_en_reg;
    pwr_next      = pwr_reg;
    to_next       = to_reg;
    pd_next       = pd_reg;
    rdata_next    = 8'h00;
    cmd_next      = '0;
    svc_next      = svc_reg;
    irq_next      = take;
    wake_next     = 1'b0;
    if (reg_rd) begin
      if (hit(reg_addr, ADDR_CORE_IC)) begin
        rdata_next = core_ic_reg;
      end else if (hit(reg_addr, ADDR_PER_FLAG)) begin
        rdata_next = per_flag_reg;
      end else if (hit(reg_addr, ADDR_PER_EN)) begin
        rdata_next = per_en_reg;
      end else if (hit(reg_addr, ADDR_PWR_CTL)) begin
        rdata_next = {5'h00, pwr_reg};
      end else if (hit(reg_addr, ADDR_STATUS)) begin
        rdata_next = {3'h0, to_reg, pd_reg, 3'h0};
      end
    end
    if (reg_wr) begin
      if (hit(reg_addr, ADDR_CORE_IC)) begin
        core_ic_next = reg_wdata;
      end
      if (hit(reg_addr, ADDR_PER_FLAG)) begin
        per_flag_next = reg_wdata;
      end
      if (hit(reg_addr, ADDR_PER_EN)) begin
        per_en_next = reg_wdata;
      end
    end
    if (return_from_interrupt_instr) begin
      core_ic_next[IC_GIE] = 1'b1;
    end
    // events after the software write, so a set beats a clear
    if (pin_edge) begin
      core_ic_next[IC_INTF] = 1'b1;
    end
    if (port_change) begin
      core_ic_next[IC_RAIF] = 1'b1;
    end
    if (tmr_roll) begin
      core_ic_next[IC_T0IF] = 1'b1;
    end
    per_flag_next = per_flag_next | per_event;
    // sleep halts the core; service resumes only once sleep_mode goes low
    if (!sleep_mode) begin
      unique case (svc_reg)
        SV_IDLE: begin
          if (instr_tick && take) begin
            svc_next = SV_LAT;
          end
        end
        SV_LAT: begin
          if (!core_ic_reg[IC_GIE]) begin
            svc_next = SV_IDLE;
          end else if (instr_tick) begin
            svc_next = SV_DLY;
          end
        end
        SV_DLY: begin
          if (!core_ic_reg[IC_GIE] || !masked_any) begin
            svc_next = SV_IDLE;
          end else if (instr_tick) begin
            svc_next           = SV_IDLE;
            cmd_next.pc_load   = 1'b1;
            cmd_next.pc_value  = PC_VECTOR;
            cmd_next.push      = 1'b1;
            cmd_next.push_addr = core_pc;
            core_ic_next[IC_GIE] = 1'b0;
            irq_next           = 1'b0;
          end
        end
      endcase
    end
    // wake leaves flags as they are; the core runs pc+1 before vectoring
    if (sleep_mode && masked_any && !wake_reg) begin
      wake_next = 1'b1;
      to_next   = 1'b1;
      pd_next   = 1'b0;
    end
    if (rst_cause.wdt_wake) begin
      to_next = 1'b0;
      pd_next = 1'b0;
    end
    if (any_rst) begin
      core_ic_next      = CORE_IC_RST;
      per_flag_next     = PER_RST;
      per_en_next       = PER_RST;
      cmd_next          = '0;
      cmd_next.pc_load  = 1'b1;
      cmd_next.pc_value = PC_RESET;
      svc_next          = SV_IDLE;
      irq_next          = 1'b0;
      wake_next         = 1'b0;
      if (rst_cause.por) begin
        to_next  = 1'b1;
        pd_next  = 1'b1;
        pwr_next = {POWER_CONTROL_REGISTER_POR[2:1], pwr_reg[POWER_CONTROL_REGISTER_BOR]};
      end else if (rst_cause.bor) begin
        to_next            = 1'b1;
        pd_next            = 1'b1;
        pwr_next[2]        = 1'b1;
        pwr_next[POWER_CONTROL_REGISTER_BOR] = 1'b0;
      end else if (rst_cause.wdt_rst) begin
        to_next = 1'b0;
      end else if (sleep_mode) begin
        to_next = 1'b1;
        pd_next = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      core_ic_reg  <= CORE_IC_RST;
      per_flag_reg <= PER_RST;
      per_en_reg   <= PER_RST;
      pwr_reg      <= POWER_CONTROL_REGISTER_POR;
      to_reg       <= 1'b1;
      pd_reg       <= 1'b1;
      rdata_reg    <= 8'h00;
      cmd_reg      <= '0;
      svc_reg      <= SV_IDLE;
      irq_reg      <= 1'b0;
      wake_reg     <= 1'b0;
    end else begin
      core_ic_reg  <= core_ic_next;
      per_flag_reg <= per_flag_next;
      per_en_reg   <= per_en_next;
      pwr_reg      <= pwr_next;
      to_reg       <= to_next;
      pd_reg       <= pd_next;
      rdata_reg    <= rdata_next;
      cmd_reg      <= cmd_next;
      svc_reg      <= svc_next;
      irq_reg      <= irq_next;
      wake_reg     <= wake_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign core_cmd  = cmd_reg;
  assign irq_req   = irq_reg;
  assign wake      = wake_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_gie_reset: assert property (any_rst |=> !core_ic_reg[IC_GIE])
    else $error("global enable survived a reset");
  a_return_from_interrupt_instr_gie: assert property (return_from_interrupt_instr && !any_rst |=> core_ic_reg[IC_GIE])
    else $error("return did not set global enable");
  a_vector_push: assert property (core_cmd.push |-> core_cmd.pc_load && core_cmd.pc_value == PC_VECTOR
                                  && !core_ic_reg[IC_GIE])
    else $error("service without vector or with enable set");
  a_svc_needs_gie: assert property (core_cmd.push |-> $past(core_ic_reg[IC_GIE], 2))
    else $error("service taken while global enable low");
  a_per_flag_set: assert property (per_event[0] && !any_rst |=> per_flag_reg[0])
    else $error("peripheral flag lost its event");
  a_tmr_roll_flag: assert property (tmr_roll && !any_rst |=> core_ic_reg[IC_T0IF])
    else $error("timer rollover missed");
  a_edge_flag: assert property (pin_edge && !any_rst |=> core_ic_reg[IC_INTF])
    else $error("pin edge did not set flag");
  a_bor_power_control_register: assert property (rst_cause.bor && !rst_cause.por |=> pwr_reg[POWER_CONTROL_REGISTER_BOR] == 1'b0)
    else $error("brown-out left power bit set");
  a_irq_gated: assert property (irq_req |-> $past(core_ic_reg[IC_GIE]) && $past(masked_any))
    else $error("request forwarded without enables");
  a_gie_drop: assert property (svc_reg != SV_IDLE && !core_ic_reg[IC_GIE] && !any_rst
                               |=> svc_reg == SV_IDLE ##1 !core_cmd.push)
    else $error("service continued after enable cleared");
  a_wake_status: assert property ($rose(wake) && !$past(any_rst) && !$past(rst_cause.wdt_wake)
                                  |-> to_reg && !pd_reg)
    else $error("wake status bits wrong");

  c_service: cover property (core_cmd.push);
  c_wake: cover property (wake);
  c_return_from_interrupt_instr: cover property (return_from_interrupt_instr ##1 core_ic_reg[IC_GIE]);
  c_bor: cover property (rst_cause.bor);
endmodule : cirv_top

// file: hw/cirv_pkg.sv
// package for the core interrupt and reset vector logic
// assumes a core that pulses one tick per instruction cycle
package cirv_pkg;
  localparam logic [7:0]  ADDR_STATUS = 8'h03;
  localparam logic [7:0]  ADDR_CORE_IC = 8'h0B;
  localparam logic [7:0]  ADDR_PER_FLAG = 8'h0C;
  localparam logic [7:0]  ADDR_PER_EN = 8'h8C;
  localparam logic [7:0]  ADDR_PWR_CTL = 8'h8E;
  localparam int          IC_GIE = 7;
  localparam int          IC_PERIPHERAL_GROUP_ENABLE = 6;
  localparam int          IC_T0IE = 5;
  localparam int          IC_INTE = 4;
  localparam int          IC_RAIE = 3;
  localparam int          IC_T0IF = 2;
  localparam int          IC_INTF = 1;
  localparam int          IC_RAIF = 0;
  localparam int          ST_TO = 4;
  localparam int          ST_PD = 3;
  localparam int          POWER_CONTROL_REGISTER_BOR = 0;
  localparam int          NUM_PER = 8;
  localparam int          PC_W = 13;
  localparam logic [7:0]  CORE_IC_RST = 8'h00;
  localparam logic [7:0]  PER_RST = 8'h00;
  localparam logic [2:0]  POWER_CONTROL_REGISTER_POR = 3'h4;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] PC_VECTOR = 13'h0004;
  localparam logic [7:0]  TIMER_ZERO_TOP = 8'hFF;
  localparam logic [7:0]  TIMER_ZERO_ZERO = 8'h00;

  typedef struct packed {
    logic            pc_load;
    logic [PC_W-1:0] pc_value;
    logic            push;
    logic [PC_W-1:0] push_addr;
  } cirv_cmd_s;

  typedef struct packed {
    logic               por;
    logic               ext_rst;
    logic               wdt_rst;
    logic               wdt_wake;
    logic               bor;
  } cirv_rst_s;

  typedef enum logic [2:0] {
    SV_IDLE = 3'b001,
    SV_LAT  = 3'b010,
    SV_DLY  = 3'b100
  } cirv_svc_e;
endpackage : cirv_pkg

// file: test/cirv_core_model.sv
// core model: instruction tick, program counter, vector and reset loads
// assumes cirv_top issues core_cmd as registered one-cycle pulses
`timescale 1ns/100ps
module cirv_core_model (
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  input  wire logic [3:0]           tick_div,
  input  wire cirv_pkg::cirv_cmd_s  core_cmd,
  output logic                      instr_tick,
  output logic [cirv_pkg::PC_W-1:0] core_pc
);
  import cirv_pkg::*;
  logic [3:0] cnt_reg;
  // tick_div lets the bench run the core fast or slow
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_reg    <= 4'h0;
      instr_tick <= 1'b0;
      core_pc    <= PC_RESET;
    end else begin
      cnt_reg    <= (cnt_reg >= tick_div) ? 4'h0 : cnt_reg + 4'h1;
      instr_tick <= (cnt_reg == 4'h0);
      if (core_cmd.pc_load) begin
        core_pc <= core_cmd.pc_value;
      end else if (instr_tick) begin
        core_pc <= core_pc + 13'h0001;
      end
    end
  end
endmodule : cirv_core_model

// file: test/test_core_interrupt_and_reset_vector_logic.sv
// self-checking bench for cirv_top with a core model on the far side
// assumes 200 MHz clock and register reads answered one cycle later
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module test_core_interrupt_and_reset_vector_logic;
  import cirv_pkg::*;
  logic        ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ext_pin = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, timer_zero = 8'h00, reg_rdata, per_event = 8'h00;
  logic        pin_edge_select = 1'b1, port_change = 1'b0, sleep_mode = 1'b0, rfi = 1'b0;
  logic        instr_tick, irq_req, wake;
  logic [3:0]  tick_div = 4'h3;
  logic [12:0] core_pc;
  cirv_rst_s   rst_cause = '0;
  cirv_cmd_s   core_cmd;
  int          num_errors = 0, checked = 0;
  always #2.5 ref_clk = ~ref_clk;
  cirv_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin(ext_pin),
    .pin_edge_select(pin_edge_select), .timer_zero(timer_zero), .port_change(port_change),
    .per_event(per_event), .instr_tick(instr_tick), .sleep_mode(sleep_mode),
    .return_from_interrupt_instr(rfi), .core_pc(core_pc), .rst_cause(rst_cause),
    .core_cmd(core_cmd), .irq_req(irq_req), .wake(wake));
  cirv_core_model core (.ref_clk(ref_clk), .sys_rst(sys_rst), .tick_div(tick_div),
    .core_cmd(core_cmd), .instr_tick(instr_tick), .core_pc(core_pc));
  task automatic close_out();
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 `CHK("reg", e, reg_rdata & m)
  endtask : rchk
  // sel 1 waits for wake, else for a vector push; never open-ended
  task automatic wait_for(input logic sel, output int n);
    n = 0;
    while ((sel ? wake : core_cmd.push) !== 1'b1) begin
      @(posedge ref_clk);
      #1 n++;
      if (n > 300) begin num_errors++; close_out(); end
    end
  endtask : wait_for
  task automatic no_push(input int c);
    repeat (c) begin @(posedge ref_clk); #1 `CHK("push", 1'b0, core_cmd.push) end
  endtask : no_push
  task automatic t_reset();
    rchk(ADDR_CORE_IC, 8'hFF, CORE_IC_RST);
    rchk(ADDR_PER_FLAG, 8'hFF, PER_RST);
    rchk(ADDR_PER_EN, 8'hFF, PER_RST);
    rchk(ADDR_PWR_CTL, 8'hFF, 8'h04);
    rchk(ADDR_STATUS, 8'h18, 8'h18);
    rchk(8'h55, 8'hFF, 8'h00);
  endtask : t_reset
  task automatic t_flags();
    @(posedge ref_clk);
    {timer_zero, port_change, per_event, ext_pin} <= {8'hFF, 1'b1, 8'hFF, 1'b1};
    @(posedge ref_clk);
    {timer_zero, port_change, per_event} <= {8'h00, 1'b0, 8'h00};
    repeat (5) @(posedge ref_clk);
    rchk(ADDR_CORE_IC, 8'hFF, 8'h07);
    rchk(ADDR_PER_FLAG, 8'hFF, 8'hFF);
    `CHK("irq", 1'b0, irq_req)
    wr(ADDR_CORE_IC, 8'h00);
    pin_edge_select <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ext_pin <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rchk(ADDR_CORE_IC, 8'h02, 8'h02);
    wr(ADDR_CORE_IC, 8'h00);
    wr(ADDR_PER_FLAG, 8'h00);
  endtask : t_flags
  task automatic t_service();
    int n;
    wr(ADDR_CORE_IC, 8'h88);
    @(posedge ref_clk) port_change <= 1'b1;
    @(posedge ref_clk) port_change <= 1'b0;
    wait_for(1'b0, n);
    `CHK("vec", PC_VECTOR, core_cmd.pc_value)
    `CHK("lat", 1'b1, n >= 6 && n <= 22)
    rchk(ADDR_CORE_IC, 8'hFF, 8'h09);
    wr(ADDR_CORE_IC, 8'h08);
    @(posedge ref_clk) rfi <= 1'b1;
    @(posedge ref_clk) rfi <= 1'b0;
    rchk(ADDR_CORE_IC, 8'hFF, 8'h88);
    // gie dropped just after the event: vector must not follow
    @(posedge ref_clk) port_change <= 1'b1;
    @(posedge ref_clk) port_change <= 1'b0;
    wr(ADDR_CORE_IC, 8'h09);
    no_push(40);
    wr(ADDR_CORE_IC, 8'h89);
    wait_for(1'b0, n);
    wr(ADDR_CORE_IC, 8'h00);
  endtask : t_service
  task automatic t_periph();
    int n;
    tick_div <= 4'h9;
    wr(ADDR_PER_EN, 8'h01);
    wr(ADDR_CORE_IC, 8'h80);
    @(posedge ref_clk) per_event <= 8'h01;
    @(posedge ref_clk) per_event <= 8'h00;
    no_push(60);
    `CHK("irq", 1'b0, irq_req)
    wr(ADDR_CORE_IC, 8'hC0);
    wait_for(1'b0, n);
    wr(ADDR_PER_FLAG, 8'h00);
    wr(ADDR_CORE_IC, 8'h00);
    tick_div <= 4'h3;
  endtask : t_periph
  task automatic t_wake();
    int n;
    sleep_mode <= 1'b1;
    pin_edge_select <= 1'b1;
    wr(ADDR_CORE_IC, 8'h10);
    @(posedge ref_clk) ext_pin <= 1'b1;
    wait_for(1'b1, n);
    rchk(ADDR_STATUS, 8'h18, 8'h10);
    rchk(ADDR_CORE_IC, 8'hFF, 8'h12);
    sleep_mode <= 1'b0;
    wr(ADDR_CORE_IC, 8'h00);
  endtask : t_wake
  task automatic t_resets();
    // wdt wake, brown-out, watchdog reset, external reset in sleep
    logic [4:0] rc [4] = '{5'h02, 5'h01, 5'h04, 5'h08};
    // watchdog reset clears timeout only; power-down keeps its brown-out value
    logic [7:0] rs [4] = '{8'h00, 8'h18, 8'h08, 8'h10};
    logic       hit;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CORE_IC, 8'h80);
      @(posedge ref_clk);
      rst_cause  <= cirv_rst_s'(rc[i]);
      sleep_mode <= (i == 0 || i == 3);
      @(posedge ref_clk) rst_cause <= '0;
      hit = 1'b0;
      repeat (3) begin
        #1 if (core_cmd.pc_load === 1'b1 && core_cmd.pc_value === PC_RESET) hit = 1'b1;
        @(posedge ref_clk);
      end
      sleep_mode <= 1'b0;
      if (i > 0) `CHK("pc0", 1'b1, hit)
      rchk(ADDR_STATUS, 8'h18, rs[i]);
      if (i > 0) rchk(ADDR_CORE_IC, 8'h80, 8'h00);
    end
    rchk(ADDR_PWR_CTL, 8'hFF, 8'h04);
  endtask : t_resets
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_flags();
    t_service();
    t_periph();
    t_wake();
    t_resets();
    close_out();
  end
endmodule : test_core_interrupt_and_reset_vector_logic
